// >>> verilog/csp_defs.svh
// Constants for the credit stream packet link: widths, offsets, counts.
// Assumes inclusion by bare name from every design file of the link.
//
// Summary of operation
// - Source may drive channel field, 1-128 bits.
// - Channel field implies channel_limit, default zero.
// - Source flags first beat with packet start.
// - Source flags last beat with packet end.
// - Empty field counts unused symbols in beat.
// - Single-symbol beats carry no empty field.
// - Packet user loads at start, held until next.
// - Per-symbol user bits travel source to sink.
// - All transfers on rising edge of clock.
// - Every source output comes from a flip-flop.
// - Sink may use its inputs combinationally.
// - Symbol width defaults 8, range 1-16368.
// - Symbols per beat range 1-16368.
// - Credit limit 1-256, default 256.
// - Error labels one per bit, MSB first.
// - Order flag puts first symbol high or low.
// - Link runs on its linked reset and clock.
// - Source asserts valid only with credits above zero.
// - Error field is a per-beat error bit mask.
// - Sink accepts every beat while credits outstanding.
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH
// ============================================================
// Stream shape
`define CSP_SYMBOL_BIT_WIDTH   8
`define CSP_BEAT_SYMBOL_COUNT  4
`define CSP_DATA_W             32
`define CSP_EMPTY_W            2
`define CSP_CHANNEL_W          1
`define CSP_CHANNEL_LIMIT      0
`define CSP_ERROR_W            2
`define CSP_PUSER_W            8
`define CSP_SUSER_PER_SYM      1
`define CSP_SUSER_W            4
`define CSP_MSB_FIRST          1'b1
`define CSP_ERROR_BIT_LABELS   "crc,overflow"
// ============================================================
// Credits
`define CSP_CREDIT_LIMIT       9'h100
`define CSP_CREDIT_W           9
// ============================================================
// Source register offsets and fields
`define CSP_REG_CTRL           8'h00
`define CSP_REG_TXDATA         8'h04
`define CSP_REG_TXMETA         8'h08
`define CSP_REG_STATUS         8'h0C
`define CSP_CTRL_ENABLE        0
`define CSP_CTRL_RETURN        1
`define CSP_META_SOP           0
`define CSP_META_EOP           1
`define CSP_META_EMPTY_LSB     2
`define CSP_META_CHAN_LSB      4
`define CSP_META_ERR_LSB       5
`define CSP_META_PUSER_LSB     8
`define CSP_META_SUSER_LSB     16
`define CSP_STAT_PEND          16
`define CSP_STAT_RET           17
`define CSP_STAT_EN            18
`endif

// >>> verilog/csp_pkg.sv
// Types shared by both ends of the credit stream packet link.
// Assumes csp_defs.svh on the include path.
`include "csp_defs.svh"
package csp_pkg;
  // ============================================================
  // One beat as carried source to sink
  typedef struct packed {
    logic [`CSP_DATA_W-1:0]    data;   // Symbols of the beat
    logic [`CSP_CHANNEL_W-1:0] chan;   // Channel number
    logic                      sop;    // Packet start
    logic                      eop;    // Packet end
    logic [`CSP_EMPTY_W-1:0]   empty;  // Unused symbols
    logic [`CSP_ERROR_W-1:0]   err;    // Error mask
    logic [`CSP_SUSER_W-1:0]   suser;  // Per-symbol user bits
  } csp_beat_t;

  // Swap symbol order when first symbol must sit in low bits
  function automatic logic [`CSP_DATA_W-1:0] csp_order(input logic [`CSP_DATA_W-1:0] d);
    logic [`CSP_DATA_W-1:0] r;
    r = d;
    if (!`CSP_MSB_FIRST) begin
      for (int i = 0; i < `CSP_BEAT_SYMBOL_COUNT; i++) begin
        r[i*`CSP_SYMBOL_BIT_WIDTH +: `CSP_SYMBOL_BIT_WIDTH] =
          d[(`CSP_BEAT_SYMBOL_COUNT-1-i)*`CSP_SYMBOL_BIT_WIDTH +: `CSP_SYMBOL_BIT_WIDTH];
      end
    end
    return r;
  endfunction : csp_order
endpackage : csp_pkg

// >>> verilog/csp_iface.sv
// Link between stream source and sink, one modport per end.
// Assumes both ends share one clock and reset.
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.svh"
interface csp_iface;
  import csp_pkg::*;
  // ============================================================
  // Source to sink
  logic                      valid;          // Beat present
  csp_beat_t                 beat;           // Beat contents
  logic [`CSP_PUSER_W-1:0]   puser;          // Per-packet user bits
  logic                      return_credit;  // One credit handed back
  // Sink to source
  logic                      update;         // Credit grant strobe
  logic [`CSP_CREDIT_W-1:0]  credit;         // Credits granted with update

  modport src (output valid, beat, puser, return_credit, input update, credit);
  modport snk (input valid, beat, puser, return_credit, output update, credit);
endinterface : csp_iface
`default_nettype wire

// >>> verilog/csp_source.sv
// Stream source end: beats are loaded over APB and sent against credits.
// Assumes an APB master on clk_in and a sink on the same clock and reset.
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.svh"
module csp_source
  import csp_pkg::*;
(
  input  wire logic        clk_in,       // 100 MHz clock
  input  wire logic        rst_in,       // Async reset, high
  input  wire logic        psel_in,      // APB select
  input  wire logic        penable_in,   // APB access phase
  input  wire logic        pwrite_in,    // APB direction
  input  wire logic [7:0]  paddr_in,     // APB byte address
  input  wire logic [31:0] pwdata_in,    // APB write data
  output logic      [31:0] prdata_out,   // APB read data
  output logic             pready_out,   // APB ready
  output logic             pslverr_out,  // APB error on unmapped
  csp_iface.src            link          // Stream link
);
  // ============================================================
  // APB slave state
  logic        pready_r, pready_nxt;     // Ready pulse
  logic        pslverr_r, pslverr_nxt;   // Error with ready
  logic [31:0] prdata_r, prdata_nxt;     // Read data
  logic        wr_done;                  // Write completes this edge

  // Request in access phase, not yet answered
  logic access;
  assign access  = psel_in & penable_in & ~pready_r;
  assign wr_done = psel_in & penable_in & pready_r & pwrite_in;

  // ============================================================
  // Control and beat staging state
  logic                     enable_r, enable_nxt;     // Sending allowed
  logic                     ret_r, ret_nxt;           // Return request
  logic                     pend_r, pend_nxt;         // Beat staged
  logic [31:0]              txdata_r, txdata_nxt;     // Staged data
  logic [31:0]              meta_r, meta_nxt;         // Staged meta word
  logic [`CSP_CREDIT_W-1:0] credits_r, credits_nxt;   // Credits held
  logic                     launch;                   // Beat leaves now
  logic                     give_back;                // Credit returns now

  // ============================================================
  // Link output flops
  logic                    valid_r, valid_nxt;
  csp_beat_t               beat_r, beat_nxt;
  logic [`CSP_PUSER_W-1:0] puser_r, puser_nxt;
  logic                    retc_r, retc_nxt;

  // Meta word of staged beat decoded into fields
  function automatic csp_beat_t unpack_meta(input logic [31:0] d, input logic [31:0] m);
    csp_beat_t b;
    b.data  = csp_order(d);
    b.sop   = m[`CSP_META_SOP];
    b.eop   = m[`CSP_META_EOP];
    b.empty = m[`CSP_META_EOP] ? m[`CSP_META_EMPTY_LSB +: `CSP_EMPTY_W]
                               : {`CSP_EMPTY_W{1'b0}};
    b.chan  = m[`CSP_META_CHAN_LSB +: `CSP_CHANNEL_W];
    b.err   = m[`CSP_META_ERR_LSB +: `CSP_ERROR_W];
    b.suser = m[`CSP_META_SUSER_LSB +: `CSP_SUSER_W];
    return b;
  endfunction : unpack_meta

  // ============================================================
  // APB answer: one cycle after access starts; meta write waits while staged
  always_comb begin
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    if (access && !(pwrite_in && paddr_in == `CSP_REG_TXMETA && pend_r)) begin
      pready_nxt = 1'b1;
      prdata_nxt = 32'h0000_0000;
      unique case (paddr_in)
        `CSP_REG_CTRL: begin
          prdata_nxt[`CSP_CTRL_ENABLE] = enable_r;
        end
        `CSP_REG_TXDATA: begin
          prdata_nxt = txdata_r;
        end
        `CSP_REG_TXMETA: begin
          prdata_nxt = meta_r;
        end
        `CSP_REG_STATUS: begin
          prdata_nxt[`CSP_CREDIT_W-1:0] = credits_r;
          prdata_nxt[`CSP_STAT_PEND]    = pend_r;
          prdata_nxt[`CSP_STAT_RET]     = ret_r;
          prdata_nxt[`CSP_STAT_EN]      = enable_r;
        end
        default: begin
          pslverr_nxt = 1'b1;  // Unmapped: error, reads zero
        end
      endcase
    end
  end

  // APB answer registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  // ============================================================
  // Credit gate and return gate
  always_comb begin
    launch    = pend_r & enable_r & (credits_r != {`CSP_CREDIT_W{1'b0}});
    give_back = ret_r & (credits_r > {{(`CSP_CREDIT_W-1){1'b0}}, launch});
  end

  // Control, staging and credit count next values
  always_comb begin
    logic [`CSP_CREDIT_W:0] sum;
    sum        = {1'b0, credits_r};
    enable_nxt = enable_r;
    ret_nxt    = ret_r & ~give_back;
    pend_nxt   = pend_r & ~launch;
    txdata_nxt = txdata_r;
    meta_nxt   = meta_r;
    if (wr_done) begin
      unique case (paddr_in)
        `CSP_REG_CTRL: begin
          enable_nxt = pwdata_in[`CSP_CTRL_ENABLE];
          if (pwdata_in[`CSP_CTRL_RETURN]) begin
            ret_nxt = 1'b1;  // Set wins over clear
          end
        end
        `CSP_REG_TXDATA: begin
          txdata_nxt = pwdata_in;
        end
        `CSP_REG_TXMETA: begin
          meta_nxt = pwdata_in;
          pend_nxt = 1'b1;
        end
        default: begin
          enable_nxt = enable_r;  // Unmapped write ignored
        end
      endcase
    end
    // Grants add; beat and return each spend one
    if (link.update) begin
      sum = sum + {1'b0, link.credit};
    end
    sum = sum - {{`CSP_CREDIT_W{1'b0}}, launch} - {{`CSP_CREDIT_W{1'b0}}, give_back};
    credits_nxt = sum[`CSP_CREDIT_W-1:0];
  end

  // Control and staging registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      enable_r  <= 1'b0;
      ret_r     <= 1'b0;
      pend_r    <= 1'b0;
      txdata_r  <= 32'h0000_0000;
      meta_r    <= 32'h0000_0000;
      credits_r <= {`CSP_CREDIT_W{1'b0}};
    end else begin
      enable_r  <= enable_nxt;
      ret_r     <= ret_nxt;
      pend_r    <= pend_nxt;
      txdata_r  <= txdata_nxt;
      meta_r    <= meta_nxt;
      credits_r <= credits_nxt;
    end
  end

  // ============================================================
  // Link outputs; fields hold between beats
  always_comb begin
    valid_nxt = launch;
    beat_nxt  = beat_r;
    puser_nxt = puser_r;
    retc_nxt  = give_back;
    if (launch) begin
      beat_nxt = unpack_meta(txdata_r, meta_r);
      if (meta_r[`CSP_META_SOP]) begin
        puser_nxt = meta_r[`CSP_META_PUSER_LSB +: `CSP_PUSER_W];
      end
    end
  end

  // Link output registers on rising edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      valid_r <= 1'b0;
      beat_r  <= '0;
      puser_r <= {`CSP_PUSER_W{1'b0}};
      retc_r  <= 1'b0;
    end else begin
      valid_r <= valid_nxt;
      beat_r  <= beat_nxt;
      puser_r <= puser_nxt;
      retc_r  <= retc_nxt;
    end
  end

  // ============================================================
  // Ports straight from flops
  assign link.valid         = valid_r;
  assign link.beat          = beat_r;
  assign link.puser         = puser_r;
  assign link.return_credit = retc_r;
  assign prdata_out         = prdata_r;
  assign pready_out         = pready_r;
  assign pslverr_out        = pslverr_r;
endmodule : csp_source
`default_nettype wire

// >>> verilog/csp_sink.sv
// Stream sink end: grants credits and presents every beat to its user.
// Assumes a source on the same clock and reset; no back-pressure exists.
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.svh"
module csp_sink
  import csp_pkg::*;
(
  input  wire logic                     clk_in,           // 100 MHz clock
  input  wire logic                     rst_in,           // Async reset, high
  input  wire logic                     grant_en_in,      // Allow credit grants
  csp_iface.snk                         link,             // Stream link
  output logic                          rx_valid_out,     // Beat received
  output csp_beat_t                     rx_beat_out,      // Beat contents
  output logic [`CSP_PUSER_W-1:0]       rx_puser_out,     // Packet user bits
  output logic [`CSP_CREDIT_W-1:0]      outstanding_out   // Credits granted, unused
);
  // ============================================================
  // Credit state
  logic [`CSP_CREDIT_W-1:0] outst_r, outst_nxt;    // Outstanding credits
  logic                     upd_r, upd_nxt;        // Grant strobe
  logic [`CSP_CREDIT_W-1:0] cred_r, cred_nxt;      // Grant amount
  // Receive state
  logic                     rxv_r, rxv_nxt;
  csp_beat_t                rxb_r, rxb_nxt;
  logic [`CSP_PUSER_W-1:0]  rxp_r, rxp_nxt;

  // Grant the headroom; nothing granted when full, so no same-cycle loop
  always_comb begin
    logic [`CSP_CREDIT_W:0] sum;
    upd_nxt  = 1'b0;
    cred_nxt = cred_r;
    sum      = {1'b0, outst_r};
    if (grant_en_in && outst_r < `CSP_CREDIT_LIMIT && !upd_r) begin
      upd_nxt  = 1'b1;
      cred_nxt = `CSP_CREDIT_LIMIT - outst_r;
      sum      = sum + {1'b0, cred_nxt};
    end
    sum = sum - {{`CSP_CREDIT_W{1'b0}}, link.valid}
              - {{`CSP_CREDIT_W{1'b0}}, link.return_credit};
    outst_nxt = sum[`CSP_CREDIT_W-1:0];
  end

  // Credit registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      outst_r <= {`CSP_CREDIT_W{1'b0}};
      upd_r   <= 1'b0;
      cred_r  <= {`CSP_CREDIT_W{1'b0}};
    end else begin
      outst_r <= outst_nxt;
      upd_r   <= upd_nxt;
      cred_r  <= cred_nxt;
    end
  end

  // ============================================================
  // Every valid beat is taken; inputs used directly
  always_comb begin
    rxv_nxt = link.valid;
    rxb_nxt = rxb_r;
    rxp_nxt = rxp_r;
    if (link.valid) begin
      rxb_nxt      = link.beat;
      rxb_nxt.data = csp_order(link.beat.data);
      rxp_nxt      = link.puser;
    end
  end

  // Receive registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rxv_r <= 1'b0;
      rxb_r <= '0;
      rxp_r <= {`CSP_PUSER_W{1'b0}};
    end else begin
      rxv_r <= rxv_nxt;
      rxb_r <= rxb_nxt;
      rxp_r <= rxp_nxt;
    end
  end

  assign link.update     = upd_r;
  assign link.credit     = cred_r;
  assign rx_valid_out    = rxv_r;
  assign rx_beat_out     = rxb_r;
  assign rx_puser_out    = rxp_r;
  assign outstanding_out = outst_r;
endmodule : csp_sink
`default_nettype wire

// >>> dv/csp_link_checker.sv
// Checker for the credit stream link, fed with the interface signals only.
// Assumes one clock and one async active-high reset for both ends.
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.svh"
module csp_link_checker
  import csp_pkg::*;
(
  input wire logic                     clk_in,         // Link clock
  input wire logic                     rst_in,         // Async reset, high
  input wire logic                     valid,          // Beat present
  input wire csp_beat_t                beat,           // Beat contents
  input wire logic [`CSP_PUSER_W-1:0]  puser,          // Packet user bits
  input wire logic                     return_credit,  // Credit handed back
  input wire logic                     update,         // Grant strobe
  input wire logic [`CSP_CREDIT_W-1:0] credit          // Grant amount
);
  // ============================================================
  // Credits held by the source, as seen on the wire
  logic [9:0] held_r;    // Held count
  logic [9:0] held_nxt;  // Next held count

  // Add grants, take off beats and returns
  always_comb begin
    held_nxt = held_r + (update ? 10'(credit) : 10'h000) - 10'(valid) - 10'(return_credit);
  end

  // Register the count
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      held_r <= 10'h000;
    end else begin
      held_r <= held_nxt;
    end
  end

  // ============================================================
  // Properties
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_single_beat;
    valid ##1 !valid;
  endsequence

  sequence s_single_grant;
    update ##1 !update;
  endsequence

  AST_EMPTY_ONLY_EOP: assert property (valid && !beat.eop |-> beat.empty == '0)
    else $error("empty count nonzero on a beat without packet end");
  AST_PUSER_HOLD: assert property (!(valid && beat.sop) |-> $stable(puser))
    else $error("packet user bits changed away from a packet start");
  AST_BEAT_HOLD: assert property (!valid |-> $stable(beat))
    else $error("beat fields moved while no beat was sent");
  AST_CREDIT_POS: assert property (valid |-> held_r != 10'h000)
    else $error("beat sent with no credit held");
  AST_RETURN_COVERED: assert property (return_credit |-> held_r > 10'(valid))
    else $error("credit returned without one to spare");
  AST_GRANT_LIMIT: assert property (update |-> held_r + 10'(credit) <= 10'h100 && credit != '0)
    else $error("grant exceeds the credit limit or is empty");
  AST_GRANT_SPACING: assert property (update |-> s_single_grant)
    else $error("grant strobes on adjacent cycles");
  AST_VALID_PULSE: assert property (valid |-> s_single_beat)
    else $error("beats on adjacent cycles");
endmodule : csp_link_checker
`default_nettype wire

// >>> dv/tb.sv
// Testbench: source and sink joined by the link, source driven over APB.
// Assumes the design files and csp_defs.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.svh"
module tb;
  import csp_pkg::*;
  logic        clk_in, rst_in;               // Clock and reset
  logic        psel, penable, pwrite;        // APB controls
  logic [7:0]  paddr;                        // APB address
  logic [31:0] pwdata, prdata;               // APB data
  logic        pready, pslverr;              // APB answer
  logic        grant_en;                     // Sink grant allow
  logic        rx_valid;                     // Sink beat strobe
  csp_beat_t   rx_beat, wire_beat;           // Sink and wire beats
  logic [7:0]  rx_puser, exp_puser;          // Packet user seen, expected
  logic [8:0]  outstanding;                  // Sink credit count
  int          n_fail, n_checks;             // Counters

  csp_iface u_csp_iface ();
  csp_source u_csp_source (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .link(u_csp_iface));
  csp_sink u_csp_sink (.clk_in(clk_in), .rst_in(rst_in), .grant_en_in(grant_en), .link(u_csp_iface),
    .rx_valid_out(rx_valid), .rx_beat_out(rx_beat), .rx_puser_out(rx_puser), .outstanding_out(outstanding));
  csp_link_checker u_csp_link_checker (.clk_in(clk_in), .rst_in(rst_in), .valid(u_csp_iface.valid),
    .beat(u_csp_iface.beat), .puser(u_csp_iface.puser), .return_credit(u_csp_iface.return_credit),
    .update(u_csp_iface.update), .credit(u_csp_iface.credit));

  // Keep the last beat seen on the wire
  always @(posedge clk_in) begin
    if (u_csp_iface.valid === 1'b1) wire_beat <= u_csp_iface.beat;
  end

  // ============================================================
  // Shared tasks
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (exp !== got) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic hung(input string what);
    n_fail++;
    $display("BAD %s expected event seen timeout", what);
    give_verdict();
  endtask : hung

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge clk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    for (i = 0; i < 80; i++) begin
      @(posedge clk_in);
      if (pready === 1'b1) break;
    end
    if (i == 80) hung("pready");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
    cmp("write error", 64'h0000_0000_0000_0000, 64'(err));
  endtask : wr

  task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    cmp(what, 64'(exp), 64'(rd));
  endtask : rd_check

  // Meta word: sop, eop, empty, channel, error, packet user, symbol user
  function automatic logic [31:0] mk(input logic s, input logic e, input logic [1:0] em, input logic ch,
                                     input logic [1:0] er, input logic [7:0] pu, input logic [3:0] su);
    return {12'h000, su, pu, 1'b0, er, ch, em, e, s};
  endfunction : mk

  // Wait for the sink strobe, then judge wire and sink
  task automatic expect_rx(input logic [31:0] d, input logic [31:0] m);
    csp_beat_t exp;
    int        i;
    exp = '{data: d, chan: m[4], sop: m[0], eop: m[1], empty: m[1] ? m[3:2] : 2'h0, err: m[6:5],
            suser: m[19:16]};
    if (m[0]) exp_puser = m[15:8];
    for (i = 0; i < 80; i++) begin
      @(posedge clk_in);
      if (rx_valid === 1'b1) break;
    end
    if (i == 80) hung("rx_valid");
    cmp("wire beat", 64'(exp), 64'(wire_beat));
    cmp("rx beat", 64'(exp), 64'(rx_beat));
    cmp("rx packet user", 64'(exp_puser), 64'(rx_puser));
  endtask : expect_rx

  task automatic send(input logic [31:0] d, input logic [31:0] m);
    wr(`CSP_REG_TXDATA, d);
    wr(`CSP_REG_TXMETA, m);
    expect_rx(d, m);
  endtask : send

  task automatic wait_out(input logic [8:0] exp);
    int i;
    for (i = 0; i < 80; i++) begin
      @(posedge clk_in);
      if (outstanding === exp) break;
    end
    if (i == 80) hung("outstanding");
    cmp("outstanding", 64'(exp), 64'(outstanding));
  endtask : wait_out

  // ============================================================
  // Scenarios
  task automatic t_no_credit();
    int seen;
    seen = 0;
    rd_check("status idle", `CSP_REG_STATUS, 32'h0000_0000);
    wr(`CSP_REG_CTRL, 32'h0000_0001);
    wr(`CSP_REG_TXDATA, 32'hA1B2_C3D4);
    wr(`CSP_REG_TXMETA, mk(1'b1, 1'b1, 2'h2, 1'b0, 2'h0, 8'h6E, 4'h9));
    repeat (20) begin
      @(posedge clk_in);
      if (u_csp_iface.valid === 1'b1) seen++;
    end
    cmp("beats without credit", 64'h0000_0000_0000_0000, 64'(seen));
    rd_check("status pending", `CSP_REG_STATUS, 32'h0005_0000);
    grant_en <= 1'b1;
    expect_rx(32'hA1B2_C3D4, mk(1'b1, 1'b1, 2'h2, 1'b0, 2'h0, 8'h6E, 4'h9));
    wait_out(9'h100);
  endtask : t_no_credit

  task automatic t_packet();
    logic [31:0] m [5];
    m[0] = mk(1'b1, 1'b0, 2'h3, 1'b0, 2'h0, 8'h5A, 4'h1);
    m[1] = mk(1'b0, 1'b0, 2'h2, 1'b1, 2'h1, 8'h33, 4'h2);
    m[2] = mk(1'b0, 1'b0, 2'h0, 1'b0, 2'h2, 8'hC4, 4'h4);
    m[3] = mk(1'b0, 1'b1, 2'h3, 1'b1, 2'h3, 8'h0F, 4'h8);
    m[4] = mk(1'b1, 1'b1, 2'h1, 1'b0, 2'h1, 8'hC3, 4'hF);
    for (int k = 0; k < 5; k++) begin
      send(32'h1234_5670 + 32'(k), m[k]);
    end
    wait_out(9'h100);
  endtask : t_packet

  task automatic t_return();
    int seen;
    grant_en <= 1'b0;
    seen = 0;
    wr(`CSP_REG_CTRL, 32'h0000_0003);
    wait_out(9'h0FF);
    rd_check("status after return", `CSP_REG_STATUS, 32'h0004_00FF);
    // Disabled source holds a staged beat although credits are held
    wr(`CSP_REG_CTRL, 32'h0000_0000);
    wr(`CSP_REG_TXDATA, 32'h0BAD_F00D);
    wr(`CSP_REG_TXMETA, mk(1'b1, 1'b1, 2'h0, 1'b1, 2'h0, 8'h77, 4'h3));
    repeat (10) begin
      @(posedge clk_in);
      if (u_csp_iface.valid === 1'b1) seen++;
    end
    cmp("beats while disabled", 64'h0000_0000_0000_0000, 64'(seen));
    wr(`CSP_REG_CTRL, 32'h0000_0001);
    expect_rx(32'h0BAD_F00D, mk(1'b1, 1'b1, 2'h0, 1'b1, 2'h0, 8'h77, 4'h3));
    wait_out(9'h0FE);
    rd_check("status after beat", `CSP_REG_STATUS, 32'h0004_00FE);
    grant_en <= 1'b1;
    wait_out(9'h100);
  endtask : t_return

  task automatic t_unmapped();
    logic [31:0] rd;
    logic        err;
    apb(1'b1, 8'h10, 32'hFFFF_FFFF, rd, err);
    cmp("unmapped write error", 64'h0000_0000_0000_0001, 64'(err));
    apb(1'b0, 8'h10, 32'h0000_0000, rd, err);
    cmp("unmapped read error", 64'h0000_0000_0000_0001, 64'(err));
    cmp("unmapped read data", 64'h0000_0000_0000_0000, 64'(rd));
  endtask : t_unmapped

  // Clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Main sequence
  initial begin
    rst_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    grant_en = 1'b0;
    exp_puser = 8'h00;
    n_fail = 0;
    n_checks = 0;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    t_no_credit();
    t_packet();
    t_return();
    t_unmapped();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
